/* shared/slb_pkg.sv */
`default_nettype none
// ****************************************************************
// Shared constants for the serial party-line line buffer.
// ****************************************************************
package slb_pkg;

  // Core clock and host link framing.
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned BAUD_RATE    = 9600;
  localparam int unsigned BAUD_CYCLES  = CLK_HZ / BAUD_RATE;
  localparam logic [3:0]  UART_LAST    = 4'h9;

  // Window in which a probed or commanded axis must answer.
  localparam int unsigned PROBE_WAIT_US = 20000;
  localparam int unsigned PROBE_CYCLES  =
    (CLK_HZ / 1_000_000) * PROBE_WAIT_US;

  // Buffering.
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [7:0]  LINE_MAX   = 8'h7F;
  localparam logic [3:0]  CMD_MAX    = 4'hE;
  localparam int unsigned NAME_SLOTS = 64;

  // Characters with a meaning of their own.
  localparam logic [7:0] CH_BS    = 8'h08;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_AMP   = 8'h26;
  localparam logic [7:0] CH_SEMI  = 8'h3B;
  localparam logic [7:0] CH_QM    = 8'h3F;
  localparam logic [7:0] NAME_A   = 8'h41;
  localparam logic [7:0] NAME_Z   = 8'h5A;
  localparam logic [7:0] NAME_LA  = 8'h61;
  localparam logic [7:0] NAME_LZ  = 8'h7A;

  // Sign-on text; the wording is arbitrary.
  localparam logic [3:0]      SIGNON_LEN  = 4'h9;
  localparam logic [71:0]     SIGNON_TEXT = {"SPL 1.0", 8'h0D, 8'h0A};

endpackage
`default_nettype wire

/* core/slb_top.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Byte FIFO between the command engine and the host transmitter.
// ****************************************************************
module slb_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,       // Core clock.
  input  wire logic             rst,       // Synchronous reset.
  input  wire logic             in_valid,  // Producer has a word.
  output logic                  in_ready,  // Room for a word.
  input  wire logic [WIDTH-1:0] in_data,   // Word in.
  output logic                  out_valid, // A word waits.
  input  wire logic             out_ready, // Consumer takes it.
  output logic      [WIDTH-1:0] out_data   // Oldest word.
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_push;
  logic             do_pop;

  // Flags come from the count so full and empty never lie.
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  // Storage write.
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr] <= in_data;
  end

  // Pointers and fill level.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      if (do_push && !do_pop)
        count <= count + 1'b1;
      else if (do_pop && !do_push)
        count <= count - 1'b1;
    end
  end
endmodule

// ****************************************************************
// Serial transmitter, 8N1.
// ****************************************************************
module slb_uart_tx
  import slb_pkg::*;
#(
  parameter int unsigned DIV = 16
) (
  input  wire logic       clk,  // Core clock.
  input  wire logic       rst,  // Synchronous reset.
  input  wire logic       go,   // Start one frame.
  input  wire logic [7:0] data, // Byte to send.
  output logic            busy, // Frame in progress.
  output logic            txd   // Serial line, idle high.
);
  logic [8:0]  shreg;
  logic [3:0]  nbit;
  logic [31:0] cnt;

  // Start bit on go, then data LSB first, then the stop bit.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy  <= 1'b0;
      txd   <= 1'b1;
      shreg <= '1;
      nbit  <= '0;
      cnt   <= '0;
    end
    else if (!busy)
    begin
      if (go)
      begin
        busy  <= 1'b1;
        txd   <= 1'b0;
        shreg <= {1'b1, data};
        nbit  <= '0;
        cnt   <= '0;
      end
    end
    else if (cnt == 32'(DIV - 1))
    begin
      cnt <= '0;
      if (nbit == UART_LAST)
      begin
        busy <= 1'b0;
        txd  <= 1'b1;
      end
      else
      begin
        txd   <= shreg[0];
        shreg <= {1'b1, shreg[8:1]};
        nbit  <= nbit + 1'b1;
      end
    end
    else
      cnt <= cnt + 1'b1;
  end
endmodule

// ****************************************************************
// Serial receiver, 8N1, sampled mid-bit.
// ****************************************************************
module slb_uart_rx
  import slb_pkg::*;
#(
  parameter int unsigned DIV = 16
) (
  input  wire logic       clk,   // Core clock.
  input  wire logic       rst,   // Synchronous reset.
  input  wire logic       rxd,   // Serial line from a pin.
  output logic            valid, // One-cycle byte strobe.
  output logic [7:0]      data   // Received byte.
);
  logic        sync1;
  logic        sync2;
  logic        busy;
  logic [3:0]  nbit;
  logic [31:0] cnt;
  logic [7:0]  shreg;

  // Two flops before anything looks at the pin.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end
    else
    begin
      sync1 <= rxd;
      sync2 <= sync1;
    end
  end

  // Half-bit preload puts every sample in the middle of its bit.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy  <= 1'b0;
      nbit  <= '0;
      cnt   <= '0;
      shreg <= '0;
      valid <= 1'b0;
      data  <= '0;
    end
    else
    begin
      valid <= 1'b0;
      if (!busy)
      begin
        if (!sync2)
        begin
          busy <= 1'b1;
          nbit <= '0;
          cnt  <= 32'(DIV / 2);
        end
      end
      else if (cnt == 32'(DIV - 1))
      begin
        cnt <= '0;
        nbit <= nbit + 1'b1;
        if (nbit == '0)
          busy <= !sync2;
        else if (nbit == UART_LAST)
        begin
          busy  <= 1'b0;
          valid <= sync2;
          data  <= shreg;
        end
        else
          shreg <= {sync2, shreg[7:1]};
      end
      else
        cnt <= cnt + 1'b1;
    end
  end
endmodule

// ****************************************************************
// Top: host port, party-line bus port and the line engine.
// ****************************************************************
module slb_top
  import slb_pkg::*;
#(
  parameter int unsigned BAUD_DIV   = BAUD_CYCLES,
  parameter int unsigned PROBE_WAIT = PROBE_CYCLES
) (
  input  wire logic CORE_CLK,  // 200 MHz core clock.
  input  wire logic SYS_RST,   // Synchronous reset, high.
  input  wire logic HOST_RXD,  // Serial from host.
  output logic      HOST_TXD,  // Serial to host.
  input  wire logic BUS_RXD,   // Serial from axis bus.
  output logic      BUS_TXD,   // Serial to axis bus.
  output logic      PARTY_N,   // Party enable, low in party.
  output logic      PARTY_LED  // Party lamp, high in party.
);
  typedef enum {
    ST_SIGNON, ST_SINGLE, ST_LOCAL, ST_SCAN_NAME, ST_SCAN_CR,
    ST_SCAN_WAIT, ST_SCAN_SHOW, ST_SCAN_END, ST_PARTY, ST_EXEC_NEXT,
    ST_EXEC_FWD, ST_EXEC_CR, ST_EXEC_WAIT, ST_RESP_NAME, ST_RESP_CHAR,
    ST_UNK_Q, ST_UNK_NAME, ST_SKIP, ST_END_CR, ST_END_LF
  } slb_state_e;

  slb_state_e           state;
  logic [7:0]           line_mem [0:127];
  logic [7:0]           line_len;
  logic [7:0]           rd_ptr;
  logic [7:0]           local_len;
  logic [3:0]           sign_idx;
  logic [7:0]           scan_name;
  logic [NAME_SLOTS-1:0] name_map;
  logic                 found_any;
  logic                 probe_hit;
  logic                 named;
  logic [7:0]           cur_name;
  logic [7:0]           hold;
  logic [3:0]           cmd_cnt;
  logic [31:0]          timer;
  logic                 hrx_valid;
  logic [7:0]           hrx_data;
  logic                 brx_valid;
  logic [7:0]           brx_data;
  logic                 btx_busy;
  logic                 htx_busy;
  logic                 bus_go;
  logic [7:0]           bus_data;
  logic                 next_bus_go;
  logic [7:0]           next_bus_data;
  logic                 push_valid;
  logic                 push_ready;
  logic [7:0]           push_data;
  logic                 q_valid;
  logic [7:0]           q_data;
  logic                 htx_go;
  logic [7:0]           htx_data;
  logic                 drain_ready;
  logic                 bus_ready;
  logic                 at_end;
  logic [7:0]           cur_ch;
  logic                 hrx_term;
  logic                 known;

  // Advance the probe name: A..Z, then a..z.
  function automatic logic [7:0] step_name(input logic [7:0] n);
    step_name = (n == NAME_Z) ? NAME_LA : n + 8'h01;
  endfunction

  // ****************************************************************
  // Serial ports and the host-bound queue.
  // ****************************************************************
  slb_uart_rx #(.DIV(BAUD_DIV)) u_host_rx (
    .clk(CORE_CLK), .rst(SYS_RST), .rxd(HOST_RXD),
    .valid(hrx_valid), .data(hrx_data));
  slb_uart_tx #(.DIV(BAUD_DIV)) u_host_tx (
    .clk(CORE_CLK), .rst(SYS_RST), .go(htx_go), .data(htx_data),
    .busy(htx_busy), .txd(HOST_TXD));
  slb_uart_rx #(.DIV(BAUD_DIV)) u_bus_rx (
    .clk(CORE_CLK), .rst(SYS_RST), .rxd(BUS_RXD),
    .valid(brx_valid), .data(brx_data));
  slb_uart_tx #(.DIV(BAUD_DIV)) u_bus_tx (
    .clk(CORE_CLK), .rst(SYS_RST), .go(bus_go), .data(bus_data),
    .busy(btx_busy), .txd(BUS_TXD));
  slb_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_queue (
    .clk(CORE_CLK), .rst(SYS_RST),
    .in_valid(push_valid), .in_ready(push_ready), .in_data(push_data),
    .out_valid(q_valid), .out_ready(drain_ready), .out_data(q_data));

  // The go flop masks the cycle before busy rises, so no byte doubles.
  assign drain_ready = !htx_busy && !htx_go;
  assign bus_ready   = !btx_busy && !bus_go;
  assign at_end      = (rd_ptr >= line_len);
  assign cur_ch      = line_mem[rd_ptr[6:0]];
  assign hrx_term    = (hrx_data == CH_CR) || (hrx_data == CH_LF);
  assign known       = (((cur_ch >= NAME_A) && (cur_ch <= NAME_Z)) ||
                        ((cur_ch >= NAME_LA) && (cur_ch <= NAME_LZ))) &&
                       name_map[6'(cur_ch - NAME_A)];

  // Host transmitter pulls from the queue one byte per frame.
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      htx_go   <= 1'b0;
      htx_data <= '0;
    end
    else
    begin
      htx_go   <= q_valid && drain_ready;
      htx_data <= q_data;
    end
  end

  // ****************************************************************
  // Host-bound bytes; the engine waits on push_ready in each state but ST_SINGLE.
  // ****************************************************************
  always_comb
  begin
    push_valid = 1'b0;
    push_data  = '0;
    case (state)
      ST_SIGNON:
      begin
        push_valid = 1'b1;
        push_data  = SIGNON_TEXT[8*(int'(SIGNON_LEN) - 1 -
                                    int'(sign_idx)) +: 8];
      end
      ST_SINGLE:
      begin
        push_valid = brx_valid;
        push_data  = brx_data;
      end
      ST_SCAN_SHOW:
      begin
        push_valid = 1'b1;
        push_data  = scan_name;
      end
      ST_SCAN_END:
      begin
        push_valid = 1'b1;
        push_data  = found_any ? CH_CR : CH_QM;
      end
      ST_RESP_NAME, ST_UNK_NAME:
      begin
        push_valid = 1'b1;
        push_data  = cur_name;
      end
      ST_RESP_CHAR:
      begin
        push_valid = 1'b1;
        push_data  = hold;
      end
      ST_UNK_Q:
      begin
        push_valid = 1'b1;
        push_data  = CH_QM;
      end
      ST_END_CR:
      begin
        push_valid = 1'b1;
        push_data  = CH_CR;
      end
      ST_END_LF:
      begin
        push_valid = 1'b1;
        push_data  = CH_LF;
      end
      default:
      begin
        push_valid = 1'b0;
        push_data  = '0;
      end
    endcase
  end

  // ****************************************************************
  // Bus-bound bytes. A single-mode byte meeting a busy bus is dropped.
  // ****************************************************************
  always_comb
  begin
    next_bus_go   = 1'b0;
    next_bus_data = bus_data;
    case (state)
      ST_SINGLE:
      begin
        next_bus_go   = hrx_valid && (hrx_data != CH_AMP) && bus_ready;
        next_bus_data = hrx_data;
      end
      ST_SCAN_NAME:
      begin
        next_bus_go   = bus_ready;
        next_bus_data = scan_name;
      end
      ST_SCAN_CR, ST_EXEC_CR:
      begin
        next_bus_go   = bus_ready;
        next_bus_data = CH_CR;
      end
      ST_EXEC_FWD:
      begin
        next_bus_go   = bus_ready && !at_end && (cur_ch != CH_SEMI) &&
                        (cmd_cnt != CMD_MAX);
        next_bus_data = cur_ch;
      end
      default:
      begin
        next_bus_go   = 1'b0;
        next_bus_data = bus_data;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      bus_go   <= 1'b0;
      bus_data <= '0;
    end
    else
    begin
      bus_go   <= next_bus_go;
      bus_data <= next_bus_data;
    end
  end

  // ****************************************************************
  // Line storage; a full line drops input other than backspace until the terminator.
  // ****************************************************************
  always_ff @(posedge CORE_CLK)
  begin
    if ((state == ST_PARTY) && hrx_valid && !hrx_term &&
        (hrx_data != CH_BS) && (line_len < LINE_MAX))
      line_mem[line_len[6:0]] <= hrx_data;
  end

  // Party lamp and enable pin follow the mode, scan included.
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      PARTY_N   <= 1'b1;
      PARTY_LED <= 1'b0;
    end
    else
    begin
      PARTY_N   <= (state == ST_SIGNON) || (state == ST_SINGLE) ||
                   (state == ST_LOCAL);
      PARTY_LED <= !((state == ST_SIGNON) || (state == ST_SINGLE) ||
                     (state == ST_LOCAL));
    end
  end

  // ****************************************************************
  // Line engine. Host input is never echoed in party mode.
  // ****************************************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      state     <= ST_SIGNON;
      line_len  <= '0;
      rd_ptr    <= '0;
      local_len <= '0;
      sign_idx  <= '0;
      scan_name <= NAME_A;
      name_map  <= '0;
      found_any <= 1'b0;
      probe_hit <= 1'b0;
      named     <= 1'b0;
      cur_name  <= '0;
      hold      <= '0;
      cmd_cnt   <= '0;
      timer     <= '0;
    end
    else
    begin
      case (state)
        ST_SIGNON:
          if (push_ready)
          begin
            sign_idx <= sign_idx + 1'b1;
            if (sign_idx == SIGNON_LEN - 4'h1)
              state <= ST_SINGLE;
          end
        ST_SINGLE:
          if (hrx_valid && (hrx_data == CH_AMP))
            state <= ST_LOCAL;
        ST_LOCAL:
          if (hrx_valid)
          begin
            if (hrx_term)
            begin
              local_len <= '0;
              if (local_len == '0)
              begin
                name_map  <= '0;
                found_any <= 1'b0;
                scan_name <= NAME_A;
                state     <= ST_SCAN_NAME;
              end
              else
                state <= ST_SINGLE;
            end
            else if (local_len != 8'hFF)
              local_len <= local_len + 1'b1;
          end
        ST_SCAN_NAME:
          if (bus_ready)
            state <= ST_SCAN_CR;
        ST_SCAN_CR:
          if (bus_ready)
          begin
            timer     <= 32'(PROBE_WAIT);
            probe_hit <= 1'b0;
            state     <= ST_SCAN_WAIT;
          end
        ST_SCAN_WAIT:
        begin
          if (brx_valid)
            probe_hit <= 1'b1;
          if (timer == '0)
          begin
            if (probe_hit || brx_valid)
            begin
              name_map[6'(scan_name - NAME_A)] <= 1'b1;
              found_any <= 1'b1;
              state     <= ST_SCAN_SHOW;
            end
            else if (scan_name == NAME_LZ)
              state <= ST_SCAN_END;
            else
            begin
              scan_name <= step_name(scan_name);
              state     <= ST_SCAN_NAME;
            end
          end
          else
            timer <= timer - 32'h1;
        end
        ST_SCAN_SHOW:
          if (push_ready)
          begin
            if (scan_name == NAME_LZ)
              state <= ST_SCAN_END;
            else
            begin
              scan_name <= step_name(scan_name);
              state     <= ST_SCAN_NAME;
            end
          end
        ST_SCAN_END:
          if (push_ready)
          begin
            line_len <= '0;
            state    <= found_any ? ST_PARTY : ST_SINGLE;
          end
        ST_PARTY:
          if (hrx_valid)
          begin
            if (hrx_term)
            begin
              rd_ptr <= '0;
              state  <= ST_EXEC_NEXT;
            end
            else if (hrx_data == CH_BS)
            begin
              if (line_len != '0)
                line_len <= line_len - 1'b1;
            end
            else if (line_len < LINE_MAX)
              line_len <= line_len + 1'b1;
          end
        ST_EXEC_NEXT:
          if (at_end)
            state <= ST_END_CR;
          else if ((cur_ch == CH_SEMI) || (cur_ch == CH_SP))
            rd_ptr <= rd_ptr + 1'b1;
          else
          begin
            cur_name <= cur_ch;
            named    <= 1'b0;
            cmd_cnt  <= '0;
            if (cur_ch == CH_AMP)
              state <= ST_SKIP;
            else if (known)
              state <= ST_EXEC_FWD;
            else
            begin
              rd_ptr <= rd_ptr + 1'b1;
              state  <= ST_UNK_Q;
            end
          end
        ST_EXEC_FWD:
          if (at_end || (cur_ch == CH_SEMI) || (cmd_cnt == CMD_MAX))
            state <= ST_EXEC_CR;
          else if (bus_ready)
          begin
            rd_ptr  <= rd_ptr + 1'b1;
            cmd_cnt <= cmd_cnt + 1'b1;
          end
        ST_EXEC_CR:
          if (bus_ready)
          begin
            timer <= 32'(PROBE_WAIT);
            state <= ST_EXEC_WAIT;
          end
        ST_EXEC_WAIT:
          if (brx_valid && (brx_data != CH_CR) && (brx_data != CH_LF))
          begin
            hold  <= brx_data;
            state <= named ? ST_RESP_CHAR : ST_RESP_NAME;
          end
          else if (timer == '0)
            state <= ST_SKIP;
          else
            timer <= timer - 32'h1;
        ST_RESP_NAME:
          if (push_ready)
          begin
            named <= 1'b1;
            state <= ST_RESP_CHAR;
          end
        ST_RESP_CHAR:
          if (push_ready)
            state <= ST_EXEC_WAIT;
        ST_UNK_Q:
          if (push_ready)
            state <= ST_UNK_NAME;
        ST_UNK_NAME:
          if (push_ready)
            state <= ST_SKIP;
        ST_SKIP:
          if (at_end)
            state <= ST_EXEC_NEXT;
          else
          begin
            rd_ptr <= rd_ptr + 1'b1;
            if (cur_ch == CH_SEMI)
              state <= ST_EXEC_NEXT;
          end
        ST_END_CR:
          if (push_ready)
            state <= ST_END_LF;
        ST_END_LF:
          if (push_ready)
          begin
            line_len <= '0;
            state    <= ST_PARTY;
          end
        default:
          state <= ST_SINGLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* bench/slb_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker for the line buffer top.
// ****************************************************************
module slb_top_sva #(
  parameter int unsigned BAUD_DIV = 16
) (
  input wire logic CORE_CLK,  // Core clock.
  input wire logic SYS_RST,   // Reset, high.
  input wire logic HOST_RXD,  // Host in.
  input wire logic HOST_TXD,  // Host out.
  input wire logic BUS_RXD,   // Bus in.
  input wire logic BUS_TXD,   // Bus out.
  input wire logic PARTY_N,   // Party pin.
  input wire logic PARTY_LED  // Party lamp.
);
  localparam int BL = BAUD_DIV - 1;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  // A fall on a line opens a bit that must stand a full bit time.
  a_reset_idle: assert property ($fell(SYS_RST) |-> HOST_TXD &&
    BUS_TXD && PARTY_N && !PARTY_LED) else $error("not idle");
  a_signon_start: assert property ($fell(SYS_RST) |->
    ##[1:8] !HOST_TXD) else $error("no sign-on start");
  a_single_first: assert property ($fell(SYS_RST) |->
    PARTY_N [*8]) else $error("not single after reset");
  a_lamp_pin: assert property (PARTY_LED != PARTY_N)
    else $error("lamp and pin disagree");
  a_scan_hold: assert property ($fell(PARTY_N) |->
    !PARTY_N [*8]) else $error("party pin glitch");
  a_scan_probe: assert property ($fell(PARTY_N) |->
    ##[0:40] $fell(BUS_TXD)) else $error("scan sent no probe");
  a_host_bit: assert property ($fell(HOST_TXD) |->
    ##BL !HOST_TXD) else $error("host bit too short");
  a_bus_bit: assert property ($fell(BUS_TXD) |->
    ##BL !BUS_TXD) else $error("bus bit too short");
  c_scan: cover property ($fell(PARTY_N));
  c_back: cover property ($rose(PARTY_N));
  c_fwd: cover property (PARTY_N && $fell(BUS_TXD));
endmodule
bind slb_top slb_top_sva #(.BAUD_DIV(BAUD_DIV)) u_sva (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .HOST_RXD(HOST_RXD),
  .HOST_TXD(HOST_TXD), .BUS_RXD(BUS_RXD), .BUS_TXD(BUS_TXD),
  .PARTY_N(PARTY_N), .PARTY_LED(PARTY_LED));
`default_nettype wire

/* bench/slb_axis_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Axis controllers A and c on the party line.
// ****************************************************************
module slb_axis_model #(
  parameter int unsigned DIV = 16
) (
  input  wire logic        clk,   // Core clock.
  input  wire logic        txd,   // Bytes from the block.
  output logic             rxd,   // Answers, idle high.
  input  wire logic [15:0] lag,   // Cycles before an answer.
  output logic [7:0]       count, // Bytes taken.
  output logic [31:0]      tail   // Last four bytes taken.
);
  logic [7:0] b;
  logic [9:0] f;
  logic       sel;
  logic       first;
  // A line led by a known name gets one result byte after its CR.
  // Input is deaf while answering; the block waits then anyway.
  initial
  begin
    rxd = 1'b1;
    count = 8'h00;
    tail = 32'h00000000;
    sel = 1'b0;
    first = 1'b1;
    forever
    begin
      @(negedge txd);
      repeat (DIV / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (DIV) @(posedge clk);
        b = {txd, b[7:1]};
      end
      repeat (DIV) @(posedge clk);
      count = count + 8'h01;
      tail = {tail[23:0], b};
      if (b == 8'h0D && sel)
      begin
        repeat (lag) @(posedge clk);
        f = {1'b1, 8'h37, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
          rxd <= f[i];
          repeat (DIV) @(posedge clk);
        end
      end
      if (first)
        sel = (b == 8'h41) || (b == 8'h63);
      first = (b == 8'h0D);
    end
  end
endmodule
`default_nettype wire

/* bench/serial_party_line_line_buffer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bench: host side driven here, axis side by the model.
// ****************************************************************
module serial_party_line_line_buffer_tb import slb_pkg::*;;
  localparam int unsigned DIV = 16;
  logic        clk, rst, host_rxd, host_txd;
  logic        bus_rxd, bus_txd, party_n, party_led;
  logic [15:0] lag;
  logic [7:0]  count, c0, mv;
  logic [31:0] tail;
  logic [7:0]  got[$];
  int          mismatches, samples_checked;
  slb_top #(.BAUD_DIV(DIV), .PROBE_WAIT(400)) dut (.CORE_CLK(clk),
    .SYS_RST(rst), .HOST_RXD(host_rxd), .HOST_TXD(host_txd),
    .BUS_RXD(bus_rxd), .BUS_TXD(bus_txd), .PARTY_N(party_n),
    .PARTY_LED(party_led));
  slb_axis_model #(.DIV(DIV)) u_axis (.clk(clk), .txd(bus_txd),
    .rxd(bus_rxd), .lag(lag), .count(count), .tail(tail));
  // Clock and host receiver; sampling mid-bit avoids edge races.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  forever
  begin
    @(negedge host_txd);
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (DIV) @(posedge clk);
      mv = {host_txd, mv[7:1]};
    end
    repeat (DIV) @(posedge clk);
    got.push_back(mv);
  end
  task automatic check(input logic [7:0] e, input logic [7:0] a);
    samples_checked++;
    if (a !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t want %h got %h", $time, e, a);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Two idle bits follow each frame so the bus side is free again.
  task automatic send(input logic [7:0] v);
    for (int i = 0; i < 12; i++)
    begin
      host_rxd <= (i == 0) ? 1'b0 : (i < 9) ? v[i - 1] : 1'b1;
      repeat (DIV) @(posedge clk);
    end
  endtask
  task automatic send_str(input string s);
    foreach (s[i])
      send(s[i]);
  endtask
  task automatic expect_str(input string s);
    int n;
    foreach (s[i])
    begin
      n = 0;
      while (got.size() == 0 && n < 40000)
      begin
        @(posedge clk);
        n++;
      end
      if (n < 40000)
        check(s[i], got.pop_front());
      else
      begin
        check(s[i], 8'hXX);
        summarize();
      end
    end
  endtask
  task automatic t_signon();
    expect_str("SPL 1.0\015\012");
    check(8'h01, {7'h00, party_n});
  endtask
  task automatic t_single();
    c0 = count;
    send_str("&x\015");
    check(c0, count);
    // Naming sequence passes straight through; the trailing CR asks.
    send_str("\016\015A\015");
    expect_str("7");
    check(c0 + 8'h04, count);
  endtask
  task automatic t_scan();
    c0 = count;
    send_str("&\015");
    check(8'h01, {7'h00, party_led});
    expect_str("Ac\015");
    check(c0 + 8'h68, count);
    check(8'h00, {7'h00, party_n});
  endtask
  task automatic t_line();
    c0 = count;
    // The answer must land inside the 400-cycle wait after the CR.
    lag <= 16'h0020;
    send_str("A+5 ;Q1;c-2X\010");
    check(c0, count);
    check(8'h00, 8'(got.size()));
    send(8'h0D);
    expect_str("A7?Qc7\015\012");
    check(8'h32, tail[15:8]);
  endtask
  task automatic t_long();
    c0 = count;
    send_str("c11111111111111111111\015");
    expect_str("c7\015\012");
    check(c0 + 8'h0F, count);
  endtask
  initial
  begin
    rst = 1'b1;
    host_rxd = 1'b1;
    lag = 16'h0000;
    mismatches = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_signon();
    t_single();
    t_scan();
    t_line();
    t_long();
    summarize();
  end
endmodule
`default_nettype wire
